// ---- src/ebrg_top.v ----
// Bus request and grant hand-over with strobe release
`timescale 1ns/1ps
`default_nettype none
`include "ebrg_consts.vh"
module ebrg_top (
  // Clock and reset
  input  wire sys_clk,
  input  wire arst_n,
  // Request from outside master
  input  wire bus_request_n,
  // Internal memory strobes from the core
  input  wire core_dms_n,
  input  wire core_pms_n,
  input  wire core_bms_n,
  input  wire core_rd_n,
  input  wire core_wr_n,
  // Processor clock output
  output reg  processor_clock_output,
  // Grant to outside master
  output reg  bus_grant_n,
  // Selects and strobes with output enables
  output reg  data_memory_select_n,
  output reg  data_memory_select_oe,
  output reg  program_memory_select_n,
  output reg  program_memory_select_oe,
  output reg  boot_memory_select_n,
  output reg  boot_memory_select_oe,
  output reg  rd_n,
  output reg  rd_oe,
  output reg  wr_n,
  output reg  wr_oe,
  // Core is held off the bus
  output reg  bus_held
);
  wire       req_n_s;
  reg        cyc_q;
  wire       cyc_end;
  reg  [2:0] state_q;
  reg  [2:0] state_d;
  wire       drive;

  // Asynchronous request synchronised in house
  ebrg_sync #(.RST_VAL(1'b1)) u_req_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     (bus_request_n),
    .dout    (req_n_s)
  );

  // Processor cycle: clock output high then low, one sys_clk each
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_q                  <= 1'b0;
      processor_clock_output <= 1'b0;
    end else begin
      cyc_q                  <= ~cyc_q;
      processor_clock_output <= ~cyc_q;
    end
  end

  // First sys_clk of a processor cycle, clock output high; next edge lowers clock output
  assign cyc_end = cyc_q;

  // Hand-over sequencer, gated steps on clock output falling edges
  always @* begin
    state_d = state_q;
    case (state_q)
      `EBRG_ST_OWN: begin
        // Request sampled in this cycle is recognised here
        if (!req_n_s && cyc_end) state_d = `EBRG_ST_SEEN;
      end
      `EBRG_ST_SEEN: begin
        // Release after the clock output rising edge
        state_d = `EBRG_ST_RELEASE;
      end
      `EBRG_ST_RELEASE: begin
        // Grant in the cycle after recognition
        if (cyc_end) state_d = `EBRG_ST_GRANTED;
      end
      `EBRG_ST_GRANTED: begin
        if (req_n_s && cyc_end) state_d = `EBRG_ST_RETURN;
      end
      `EBRG_ST_RETURN: begin
        state_d = `EBRG_ST_OWN;
      end
      default: state_d = `EBRG_ST_OWN;
    endcase
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) state_q <= `EBRG_ST_OWN;
    else         state_q <= state_d;
  end

  // Drive only while owning, and in the cycle of recognition
  assign drive = (state_d == `EBRG_ST_OWN) ||
                 (state_d == `EBRG_ST_SEEN);

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_grant_n              <= 1'b1;
      bus_held                 <= 1'b0;
      data_memory_select_n     <= 1'b1;
      data_memory_select_oe    <= 1'b0;
      program_memory_select_n  <= 1'b1;
      program_memory_select_oe <= 1'b0;
      boot_memory_select_n     <= 1'b1;
      boot_memory_select_oe    <= 1'b0;
      rd_n                     <= 1'b1;
      rd_oe                    <= 1'b0;
      wr_n                     <= 1'b1;
      wr_oe                    <= 1'b0;
    end else begin
      // Grant low only once strobes already released
      bus_grant_n <= ~(state_d == `EBRG_ST_GRANTED);
      bus_held    <= ~drive;
      data_memory_select_oe    <= drive;
      program_memory_select_oe <= drive;
      boot_memory_select_oe    <= drive;
      rd_oe                    <= drive;
      wr_oe                    <= drive;
      data_memory_select_n     <= drive ? core_dms_n : 1'b1;
      program_memory_select_n  <= drive ? core_pms_n : 1'b1;
      boot_memory_select_n     <= drive ? core_bms_n : 1'b1;
      rd_n                     <= drive ? core_rd_n  : 1'b1;
      wr_n                     <= drive ? core_wr_n  : 1'b1;
    end
  end
endmodule // ebrg_top
`default_nettype wire

// ---- src/ebrg_consts.vh ----
// Constants for the external bus request and grant block
// Summary of operation
// - A request caught in a processor cycle is recognised in the next cycle, else in the one after.
// - Grant goes low in the processor cycle after the one where the request was recognised.
// - The request may arrive asynchronously; the block synchronises it itself.
// - On grant, selects and strobes are released after a clock output rising edge, before grant falls.
`ifndef EBRG_CONSTS_VH
`define EBRG_CONSTS_VH
`define EBRG_CLK_MHZ        10
`define EBRG_REQ_PULSE_NS   10
`define EBRG_CYC_DIV        2
`define EBRG_ST_OWN         3'h0
`define EBRG_ST_SEEN        3'h1
`define EBRG_ST_RELEASE     3'h2
`define EBRG_ST_GRANTED     3'h3
`define EBRG_ST_RETURN      3'h4
`endif

// ---- src/ebrg_sync.v ----
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module ebrg_sync #(
  parameter RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire arst_n,
  // Level in and out
  input  wire din,
  output wire dout
);
  reg meta_q;
  reg sync_q;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // ebrg_sync
`default_nettype wire

// ---- bench/ebrg_chk.sv ----
// Checker for the bus hand-over block
`timescale 1ns/1ps
`default_nettype none
module ebrg_chk (
  // Clock, reset, request and grant
  input wire sys_clk, arst_n, bus_request_n, bus_grant_n,
  // Output enables
  input wire data_memory_select_oe, rd_oe, wr_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence hand_back_s; !wr_oe ##1 wr_oe; endsequence
  req_seen_a: assert property ($fell(bus_request_n) |-> ##[4:7] !bus_grant_n)
    else $error("grant missing after request");
  grant_late_a: assert property ($fell(bus_request_n) |-> bus_grant_n[*4])
    else $error("grant too early");
  bus_free_a: assert property (!bus_grant_n |-> !wr_oe && !data_memory_select_oe)
    else $error("strobe driven under grant");
  free_first_a: assert property ($fell(bus_grant_n) |-> !$past(rd_oe))
    else $error("release after grant");
  grant_hold_a: assert property (!bus_grant_n && !bus_request_n |=> !bus_grant_n)
    else $error("grant dropped early");
  grant_drop_a: assert property ($rose(bus_request_n) |-> ##[1:6] bus_grant_n)
    else $error("grant kept too long");
  drive_back_a: assert property ($rose(bus_grant_n) |-> hand_back_s)
    else $error("strobes not driven again");
endmodule // ebrg_chk
bind ebrg_top ebrg_chk chk_u (.*);
`default_nettype wire

// ---- bench/ebrg_master.sv ----
// Outside bus master model
`timescale 1ns/1ps
`default_nettype none
module ebrg_master (
  input  wire        sys_clk, go, bus_grant_n,
  input  wire  [3:0] hold,
  output logic       bus_request_n
);
  initial bus_request_n = 1'b1;
  // Request is held until granted, then for hold more cycles
  always @(posedge sys_clk) if (go) begin
    #3 bus_request_n = 1'b0;
    wait (!bus_grant_n);
    repeat (hold) @(posedge sys_clk);
    #3 bus_request_n = 1'b1;
  end
endmodule // ebrg_master
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the bus hand-over block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0, arst_n = 1'b0, go = 1'b0;
  logic [3:0] hold = 4'h0;
  int errors = 0, cmp_count = 0, cyc = 0, n;
  wire core_dms_n, core_pms_n, core_bms_n, core_rd_n, core_wr_n;
  wire bus_request_n, processor_clock_output, bus_grant_n, bus_held, rd_n;
  wire data_memory_select_n, data_memory_select_oe, program_memory_select_n;
  wire program_memory_select_oe, boot_memory_select_n, boot_memory_select_oe;
  wire rd_oe, wr_n, wr_oe;
  assign {core_dms_n, core_pms_n, core_bms_n, core_rd_n, core_wr_n} = cyc[4:0];
  ebrg_top dut_u (.*);
  ebrg_master mst_u (.*);
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= #3 cyc + 1;
    if (cyc == 3000) begin
      errors++;
      summarize;
    end
  end
  task chk(string s, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %b got %b", s, e, g);
    end
  endtask
  task chk_v(string s, logic [4:0] e, logic [4:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task t_drive;
    logic [4:0] e;
    logic       p;
    repeat (4) begin
      @(posedge sys_clk);
      e = {core_dms_n, core_pms_n, core_bms_n, core_rd_n, core_wr_n};
      p = processor_clock_output;
      #3 chk_v("strobes", e, {data_memory_select_n, program_memory_select_n,
                              boot_memory_select_n, rd_n, wr_n});
      chk("clock out", ~p, processor_clock_output);
      chk("not held", 1'b0, bus_held);
    end
    $display("test drive done");
  endtask
  task t_reset;
    chk("grant in reset", 1'b1, bus_grant_n);
    chk("oe in reset", 1'b0, wr_oe);
    #3 arst_n = 1'b1;
    @(posedge sys_clk);
    #3 chk("oe after reset", 1'b1, data_memory_select_oe & rd_oe & wr_oe);
    $display("test reset done");
  endtask
  task t_grant(logic [3:0] h);
    @(posedge sys_clk);
    #3 go = 1'b1;
    hold = h;
    @(posedge sys_clk);
    #3 go = 1'b0;
    for (n = 0; bus_grant_n !== 1'b0 && n < 20; n++) @(posedge sys_clk) #3;
    chk("grant delay", 1'b1, n inside {5, 6});
    chk("oe off", 1'b0, program_memory_select_oe | boot_memory_select_oe);
    chk("rd released", 1'b1, rd_n & bus_held);
    repeat (h) @(posedge sys_clk);
    #3 chk("grant held", 1'b0, bus_grant_n);
    for (n = 0; bus_grant_n !== 1'b1 && n < 20; n++) @(posedge sys_clk) #3;
    chk("grant back", 1'b1, n < 7);
    @(posedge sys_clk);
    #3 chk("oe back", 1'b1, wr_oe & rd_oe & boot_memory_select_oe);
    $display("test grant hold %0d done", h);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    t_reset;
    t_drive;
    t_grant(4'h0);
    t_grant(4'h7);
    summarize;
  end
endmodule // testbench
`default_nettype wire
